// File: verilog/rpmc_pkg.sv
// Purpose: Shared constants for the regulator power mode control block.
// Assumes: APB with 32-bit data, CLK at 125 MHz.
// Notes: _ADDR values are byte addresses on the APB bus; RPMC_MISC_CTRL_OFS is a word offset.
package rpmc_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [11:0] RPMC_MISC_CTRL_OFS = 12'h02F;
   localparam logic [11:0] RPMC_MISC_CTRL_ADDR = 12'h0BC;
   localparam logic [11:0] RPMC_STATUS_ADDR = 12'h0C0;
   localparam int RPMC_IGN_BIT = 7;
   localparam int RPMC_CMP_BIT = 6;
   localparam int RPMC_PRON_BIT = 0;
   localparam logic RPMC_CMP_RESET = 1'b0;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int RPMC_POR_DELAY_CYC = 4064;
   localparam int RPMC_CLK_MHZ = 125;
   // ************************************************************
   // Power modes
   // ************************************************************
   typedef enum logic [2:0] {
      RPMC_OFF = 3'b001,
      RPMC_STANDBY = 3'b010,
      RPMC_UP = 3'b100
   } rpmc_mode_t;
endpackage

// File: verilog/rpmc_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter and rise pulse.
// Assumes: Pin is asynchronous to CLK.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module rpmc_sync (
   input wire logic CLK,
   input wire logic RST,
   input wire logic pin_in,
   output logic level_out,
   output logic rise_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic rise;
   } rpmc_sync_t;
   rpmc_sync_t st_q;
   rpmc_sync_t st_d;
   always_comb begin
      st_d = st_q;
      st_d.s1 = pin_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.rise = 1'b0;
      // A change counts only once stages two and three agree.
      if (st_q.s2 == st_q.s3) begin
         st_d.lvl = st_q.s3;
         st_d.rise = st_q.s3 & ~st_q.lvl;
      end
   end
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign level_out = st_q.lvl;
   assign rise_out = st_q.rise;
endmodule // rpmc_sync

// File: verilog/rpmc_top.sv
// Purpose: Regulator power mode control with its control register on APB.
// Assumes: Option strap inputs are static; BATT_OK and VDD_OK come from
//    analog comparators; pins are asynchronous and synchronised here.
// Notes: The held regulator latch models the secondary-supply latch, so it
//    ignores RST; it is initialised once by the power-on input POR.
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
module rpmc_top import rpmc_pkg::*; #(
   parameter int POR_CYCLES = RPMC_POR_DELAY_CYC
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic POR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic IGNITION_PIN,
   input wire logic BUS_PIN,
   input wire logic REGULATOR_OPTION_ENABLE,
   input wire logic BUS_WAKE_OPTION,
   input wire logic SUPPLY_CLAMP_OPTION,
   input wire logic BATT_OK,
   input wire logic VDD_OK,
   input wire logic TIMER_COMPARE_OUTPUT,
   input wire logic PORT_B_PIN_SIX_GPIO_OUT,
   input wire logic PORT_B_PIN_SIX_GPIO_OE,
   output logic PORT_B_PIN_SIX_OUT,
   output logic PORT_B_PIN_SIX_OE,
   output logic REGULATOR_ENABLE,
   output logic SUPPLY_CLAMP_ON,
   output logic UNDERVOLTAGE_RESET
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic cmp_sel;
      logic pr_on;
      logic held;
      logic clamp;
      rpmc_mode_t mode;
      logic [12:0] por_cnt;
      logic uv_rst;
      logic bat_s1;
      logic bat_s2;
      logic bat_s3;
      logic bat_ok;
      logic vdd_s1;
      logic vdd_s2;
      logic vdd_s3;
      logic vdd_ok;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic pb_out;
      logic pb_oe;
      logic reg_en;
   } rpmc_state_t;
   rpmc_state_t st_q;
   rpmc_state_t st_d;
   logic ign_lvl;
   logic ign_rise;
   logic bus_rise;
   logic wake;
   logic wr_ctrl;
   logic access;
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   // The synchronisers live with the held latch, so only POR clears them.
   // An RST pulse then cannot fake a wake edge on a pin that is already high.
   rpmc_sync u_ign_sync (
      .CLK(CLK),
      .RST(POR),
      .pin_in(IGNITION_PIN),
      .level_out(ign_lvl),
      .rise_out(ign_rise)
   );
   rpmc_sync u_bus_sync (
      .CLK(CLK),
      .RST(POR),
      .pin_in(BUS_PIN),
      .level_out(),
      .rise_out(bus_rise)
   );
   assign wake = ign_rise | (bus_rise & BUS_WAKE_OPTION);
   assign access = PSEL & PENABLE & ~st_q.ready;
   assign wr_ctrl = access & PWRITE & (PADDR == RPMC_MISC_CTRL_ADDR);
   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      st_d = st_q;
      st_d.bat_s1 = BATT_OK;
      st_d.bat_s2 = st_q.bat_s1;
      st_d.bat_s3 = st_q.bat_s2;
      if (st_q.bat_s2 == st_q.bat_s3) begin
         st_d.bat_ok = st_q.bat_s3;
      end
      st_d.vdd_s1 = VDD_OK;
      st_d.vdd_s2 = st_q.vdd_s1;
      st_d.vdd_s3 = st_q.vdd_s2;
      if (st_q.vdd_s2 == st_q.vdd_s3) begin
         st_d.vdd_ok = st_q.vdd_s3;
      end
      // APB slave: one wait state per access, PREADY registered one cycle into the access phase.
      st_d.ready = access;
      st_d.slverr = 1'b0;
      st_d.rdata = 32'h0;
      if (access) begin
         if (PADDR == RPMC_MISC_CTRL_ADDR) begin
            st_d.rdata[RPMC_IGN_BIT] = ign_lvl & REGULATOR_OPTION_ENABLE;
            st_d.rdata[RPMC_CMP_BIT] = st_q.cmp_sel;
            st_d.rdata[RPMC_PRON_BIT] = st_q.pr_on;
         end else if (PADDR == RPMC_STATUS_ADDR) begin
            st_d.rdata = {24'h0, st_q.held, st_q.clamp, st_q.uv_rst, 2'h0, st_q.mode};
         end else begin
            st_d.slverr = 1'b1;
         end
      end
      if (wr_ctrl) begin
         st_d.cmp_sel = PWDATA[RPMC_CMP_BIT];
         st_d.pr_on = PWDATA[RPMC_PRON_BIT];
         st_d.held = PWDATA[RPMC_PRON_BIT];
         if (SUPPLY_CLAMP_OPTION && !PWDATA[RPMC_PRON_BIT]) begin
            st_d.clamp = 1'b1;
         end
      end
      // A wake edge wins over a simultaneous zero write.
      if (wake) begin
         st_d.held = 1'b1;
         st_d.clamp = 1'b0;
      end
      if (!SUPPLY_CLAMP_OPTION) begin
         st_d.clamp = 1'b0;
      end
      st_d.reg_en = REGULATOR_OPTION_ENABLE & st_q.held & st_q.bat_ok;
      st_d.pb_out = st_q.cmp_sel ? TIMER_COMPARE_OUTPUT : PORT_B_PIN_SIX_GPIO_OUT;
      st_d.pb_oe = st_q.cmp_sel | PORT_B_PIN_SIX_GPIO_OE;
      case (st_q.mode)
         RPMC_OFF: begin
            if (st_q.bat_ok) begin
               st_d.mode = RPMC_STANDBY;
            end
         end
         RPMC_STANDBY: begin
            if (!st_q.bat_ok) begin
               st_d.mode = RPMC_OFF;
            end else if (st_q.reg_en && st_q.vdd_ok) begin
               st_d.mode = RPMC_UP;
            end
         end
         RPMC_UP: begin
            if (!st_q.bat_ok) begin
               st_d.mode = RPMC_OFF;
            end else if (!st_q.reg_en || !st_q.vdd_ok) begin
               st_d.mode = RPMC_STANDBY;
            end
         end
         default: begin
            st_d.mode = RPMC_OFF;
         end
      endcase
      // Undervoltage reset asserts on supply loss and releases after the delay.
      if (!st_q.vdd_ok || !st_q.bat_ok) begin
         st_d.uv_rst = 1'b1;
         st_d.por_cnt = 13'h0000;
      end else if (st_q.uv_rst) begin
         if (st_q.por_cnt >= 13'(POR_CYCLES - 1)) begin
            st_d.uv_rst = 1'b0;
         end else begin
            st_d.por_cnt = st_q.por_cnt + 13'h0001;
         end
      end
   end
   // ************************************************************
   // Registers
   // ************************************************************
   // The held latch and regulator on bit sit on the secondary supply, so
   // RST leaves them alone; only POR gives them a starting value.
   always_ff @(posedge CLK) begin
      if (POR) begin
         st_q <= '0;
         st_q.mode <= RPMC_OFF;
         st_q.uv_rst <= 1'b1;
      end else if (RST) begin
         st_q <= st_d;
         st_q.cmp_sel <= RPMC_CMP_RESET;
         st_q.ready <= 1'b0;
         st_q.rdata <= 32'h0;
         st_q.pr_on <= st_q.pr_on;
      end else begin
         st_q <= st_d;
      end
   end
   assign PRDATA = st_q.rdata;
   assign PREADY = st_q.ready;
   assign PSLVERR = st_q.slverr;
   assign PORT_B_PIN_SIX_OUT = st_q.pb_out;
   assign PORT_B_PIN_SIX_OE = st_q.pb_oe;
   assign REGULATOR_ENABLE = st_q.reg_en;
   assign SUPPLY_CLAMP_ON = st_q.clamp;
   assign UNDERVOLTAGE_RESET = st_q.uv_rst;
   // ************************************************************
   // Checks
   // ************************************************************
   a_write_copies_latch: assert property (@(posedge CLK) disable iff (RST || POR)
      (wr_ctrl && !wake) |=> (st_q.held == $past(PWDATA[RPMC_PRON_BIT])))
      else $error("Held latch did not follow control write.");
   a_wake_sets_latch: assert property (@(posedge CLK) disable iff (RST || POR)
      wake |=> st_q.held && !st_q.clamp)
      else $error("Wake edge did not set held latch.");
   a_no_pin_turnoff: assert property (@(posedge CLK) disable iff (RST || POR)
      (st_q.held && !wr_ctrl) |=> st_q.held)
      else $error("Held latch cleared without a write.");
   a_option_gates_reg: assert property (@(posedge CLK) disable iff (RST || POR)
      !REGULATOR_OPTION_ENABLE |=> !REGULATOR_ENABLE)
      else $error("Regulator enabled without option.");
   a_ign_flag_read: assert property (@(posedge CLK) disable iff (RST || POR)
      (access && !PWRITE && PADDR == RPMC_MISC_CTRL_ADDR && !REGULATOR_OPTION_ENABLE)
      |=> !PRDATA[RPMC_IGN_BIT])
      else $error("Ignition flag visible without option.");
   a_cmp_routes_pin: assert property (@(posedge CLK) disable iff (RST || POR)
      st_q.cmp_sel |=> PORT_B_PIN_SIX_OE && PORT_B_PIN_SIX_OUT == $past(TIMER_COMPARE_OUTPUT))
      else $error("Compare output not routed to pin.");
   a_cmp_reset_clear: assert property (@(posedge CLK) disable iff (POR)
      RST |=> !st_q.cmp_sel)
      else $error("Compare select not cleared by reset.");
   a_pron_survives: assert property (@(posedge CLK) disable iff (POR)
      RST |=> st_q.pr_on == $past(st_q.pr_on))
      else $error("Regulator on bit changed by reset.");
   a_uv_on_loss: assert property (@(posedge CLK) disable iff (RST || POR)
      (!st_q.vdd_ok) |=> UNDERVOLTAGE_RESET)
      else $error("Undervoltage reset not asserted.");
   a_apb_one_wait: assert property (@(posedge CLK) disable iff (RST || POR)
      (PSEL && PENABLE && !PREADY) |=> PREADY)
      else $error("APB answer late.");
   // ************************************************************
   // Checks: register bus
   // ************************************************************
   a_pready_pulse: assert property (@(posedge CLK) disable iff (RST || POR)
      PREADY |=> !PREADY)
      else $error("Ready held longer than one cycle.");
   a_slverr_unmapped: assert property (@(posedge CLK) disable iff (RST || POR)
      (access && PADDR != RPMC_MISC_CTRL_ADDR && PADDR != RPMC_STATUS_ADDR) |=> PSLVERR)
      else $error("Unmapped access not refused.");
   a_other_write_ignored: assert property (@(posedge CLK) disable iff (RST || POR)
      (access && PWRITE && PADDR != RPMC_MISC_CTRL_ADDR) |=> (st_q.pr_on == $past(st_q.pr_on)) && (st_q.cmp_sel == $past(st_q.cmp_sel)))
      else $error("Write to another address changed the control register.");
   a_ctrl_zero_bits: assert property (@(posedge CLK) disable iff (RST || POR)
      (access && PADDR == RPMC_MISC_CTRL_ADDR) |=> (PRDATA[5:1] == 5'h00) && (PRDATA[31:8] == 24'h000000))
      else $error("Unused control bits read as nonzero.");
   a_ign_flag_level: assert property (@(posedge CLK) disable iff (RST || POR)
      (access && !PWRITE && PADDR == RPMC_MISC_CTRL_ADDR && REGULATOR_OPTION_ENABLE) |=> PRDATA[RPMC_IGN_BIT] == $past(ign_lvl))
      else $error("Ignition flag does not show pin level.");
   a_pron_write: assert property (@(posedge CLK) disable iff (RST || POR)
      wr_ctrl |=> st_q.pr_on == $past(PWDATA[RPMC_PRON_BIT]))
      else $error("Regulator on bit did not take the write.");
   a_cmp_write: assert property (@(posedge CLK) disable iff (RST || POR)
      wr_ctrl |=> st_q.cmp_sel == $past(PWDATA[RPMC_CMP_BIT]))
      else $error("Compare select did not take the write.");
   a_reset_idle_bus: assert property (@(posedge CLK) disable iff (POR)
      RST |=> !PREADY)
      else $error("Ready seen during reset.");
   // ************************************************************
   // Checks: port pin, regulator and clamp
   // ************************************************************
   a_gpio_passes: assert property (@(posedge CLK) disable iff (RST || POR)
      !st_q.cmp_sel |=> (PORT_B_PIN_SIX_OUT == $past(PORT_B_PIN_SIX_GPIO_OUT))
      && (PORT_B_PIN_SIX_OE == $past(PORT_B_PIN_SIX_GPIO_OE)))
      else $error("Port pin not left to general I/O.");
   a_zero_write_off: assert property (@(posedge CLK) disable iff (RST || POR)
      (wr_ctrl && !wake && !PWDATA[RPMC_PRON_BIT]) |=> ##1 !REGULATOR_ENABLE)
      else $error("Regulator still enabled after zero write.");
   a_held_keeps_on: assert property (@(posedge CLK) disable iff (RST || POR)
      (st_q.held && st_q.bat_ok && REGULATOR_OPTION_ENABLE) |=> REGULATOR_ENABLE)
      else $error("Regulator not enabled while latch is set.");
   a_off_without_batt: assert property (@(posedge CLK) disable iff (RST || POR)
      !st_q.bat_ok |=> !REGULATOR_ENABLE)
      else $error("Regulator enabled without battery.");
   a_ign_wake: assert property (@(posedge CLK) disable iff (RST || POR)
      ign_rise |=> st_q.held)
      else $error("Ignition edge did not wake the regulator.");
   a_bus_wake: assert property (@(posedge CLK) disable iff (RST || POR)
      (bus_rise && BUS_WAKE_OPTION) |=> st_q.held)
      else $error("Bus edge did not wake the regulator.");
   a_bus_needs_opt: assert property (@(posedge CLK) disable iff (RST || POR)
      (bus_rise && !BUS_WAKE_OPTION && !ign_rise && !st_q.held && !wr_ctrl) |=> !st_q.held)
      else $error("Bus edge woke the regulator without option.");
   a_clamp_on_zero: assert property (@(posedge CLK) disable iff (RST || POR)
      (wr_ctrl && !wake && SUPPLY_CLAMP_OPTION && !PWDATA[RPMC_PRON_BIT]) |=> SUPPLY_CLAMP_ON)
      else $error("Clamp not turned on by zero write.");
   a_clamp_off_wake: assert property (@(posedge CLK) disable iff (RST || POR)
      wake |=> !SUPPLY_CLAMP_ON)
      else $error("Clamp still on after wake edge.");
   a_clamp_holds: assert property (@(posedge CLK) disable iff (RST || POR)
      (SUPPLY_CLAMP_ON && SUPPLY_CLAMP_OPTION && !wake) |=> SUPPLY_CLAMP_ON)
      else $error("Clamp released without a wake edge.");
   a_clamp_needs_opt: assert property (@(posedge CLK) disable iff (RST || POR)
      !SUPPLY_CLAMP_OPTION |=> !SUPPLY_CLAMP_ON)
      else $error("Clamp on without clamp option.");
   // ************************************************************
   // Checks: power modes and undervoltage reset
   // ************************************************************
   a_mode_off_batt: assert property (@(posedge CLK) disable iff (RST || POR)
      !st_q.bat_ok |=> st_q.mode == RPMC_OFF)
      else $error("Mode not off without battery.");
   a_standby_from_off: assert property (@(posedge CLK) disable iff (RST || POR)
      (st_q.mode == RPMC_OFF && st_q.bat_ok) |=> st_q.mode == RPMC_STANDBY)
      else $error("Standby not entered with battery.");
   a_up_entry: assert property (@(posedge CLK) disable iff (RST || POR)
      (st_q.mode == RPMC_STANDBY && st_q.bat_ok && st_q.reg_en && st_q.vdd_ok) |=> st_q.mode == RPMC_UP)
      else $error("Power-up not entered with regulator on.");
   a_no_early_up: assert property (@(posedge CLK) disable iff (RST || POR)
      (st_q.mode != RPMC_UP && (!st_q.reg_en || !st_q.vdd_ok)) |=> st_q.mode != RPMC_UP)
      else $error("Power-up entered without regulator output.");
   a_up_leaves_loss: assert property (@(posedge CLK) disable iff (RST || POR)
      (st_q.mode == RPMC_UP && (!st_q.reg_en || !st_q.vdd_ok)) |=> st_q.mode != RPMC_UP)
      else $error("Power-up kept after regulator output loss.");
   a_uv_no_early: assert property (@(posedge CLK) disable iff (RST || POR)
      (UNDERVOLTAGE_RESET && !st_q.vdd_ok) |=> ##1 UNDERVOLTAGE_RESET)
      else $error("Undervoltage reset released too early.");
   a_uv_holds_delay: assert property (@(posedge CLK) disable iff (RST || POR)
      $fell(UNDERVOLTAGE_RESET) |-> st_q.por_cnt >= 13'(POR_CYCLES - 1))
      else $error("Undervoltage reset shorter than the delay.");
endmodule // rpmc_top

// File: sim/rpmc_top_bench.sv
// Purpose: Self-checking bench for the regulator power mode control block.
// Assumes: APB master tasks; POR_CYCLES shortened to 8 to keep the run short.
// Notes: Pin effects are judged after a settle span that covers the synchroniser.
`timescale 1ns/100ps
module rpmc_top_bench import rpmc_pkg::*;;
   localparam int PC = 8;
   localparam logic [11:0] CTRL = RPMC_MISC_CTRL_ADDR;
   localparam logic [11:0] ST = RPMC_STATUS_ADDR;
   logic clk = 1'h0, rst = 1'h1, por = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, pb_out, pb_oe, reg_en, clamp, uvr;
   logic ign = 1'h0, bus = 1'h0, ropt = 1'h1, bwopt = 1'h0, scopt = 1'h0, batt = 1'h1, vdd = 1'h1;
   logic cmp_in = 1'h0, gpio_out = 1'h0, gpio_oe = 1'h0;
   int failures = 0, check_count = 0;
   always #4 clk = ~clk;
   rpmc_top #(.POR_CYCLES(PC)) rpmc_top_inst (.CLK(clk), .RST(rst), .POR(por), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .IGNITION_PIN(ign), .BUS_PIN(bus), .REGULATOR_OPTION_ENABLE(ropt), .BUS_WAKE_OPTION(bwopt),
      .SUPPLY_CLAMP_OPTION(scopt), .BATT_OK(batt), .VDD_OK(vdd), .TIMER_COMPARE_OUTPUT(cmp_in),
      .PORT_B_PIN_SIX_GPIO_OUT(gpio_out), .PORT_B_PIN_SIX_GPIO_OE(gpio_oe), .PORT_B_PIN_SIX_OUT(pb_out),
      .PORT_B_PIN_SIX_OE(pb_oe), .REGULATOR_ENABLE(reg_en), .SUPPLY_CLAMP_ON(clamp), .UNDERVOLTAGE_RESET(uvr));
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Starts on a fresh edge so a released strobe is never raised again in the same step.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
      output logic er);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
      logic [31:0] d;
      logic e;
      apb(1'h0, a, 32'h0, d, e);
      chk(nm, exp, d & m);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic e;
      apb(1'h1, a, d, x, e);
   endtask
   task automatic settle;
      repeat (10) @(posedge clk);
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic s_reset;
      logic [31:0] d;
      logic e;
      rdc(CTRL, 32'hFFFFFFFF, 32'h0, "ctrl after power on");
      rdc(ST, 32'h7, 32'h2, "mode standby");
      apb(1'h1, 12'h0C4, 32'hFF, d, e);
      chk("unmapped write error", 32'h1, {31'h0, e});
      apb(1'h0, 12'h0C4, 32'h0, d, e);
      chk("unmapped read data", 32'h0, d);
   endtask
   task automatic s_wake;
      ign <= 1'h1;
      settle;
      chk("enable on wake", 32'h1, {31'h0, reg_en});
      rdc(CTRL, 32'hFFFFFFFF, 32'h80, "ctrl after wake");
      rdc(ST, 32'h87, 32'h84, "mode up latch set");
   endtask
   task automatic s_cmp;
      cmp_in <= 1'h1;
      gpio_out <= 1'h0;
      wr(CTRL, 32'hFF);
      rdc(CTRL, 32'hFFFFFFFF, 32'hC1, "ctrl readback");
      chk("pin with compare", 32'h3, {30'h0, pb_out, pb_oe});
      wr(CTRL, 32'h01);
      gpio_out <= 1'h1;
      settle;
      chk("pin as gpio", 32'h2, {30'h0, pb_out, pb_oe});
   endtask
   task automatic s_off;
      scopt <= 1'h1;
      rdc(CTRL, 32'h80, 32'h80, "flag before off");
      wr(CTRL, 32'h0);
      settle;
      chk("off by write", 32'h0, {31'h0, reg_en});
      chk("clamp on", 32'h1, {31'h0, clamp});
      rdc(ST, 32'hC7, 32'h42, "standby after off");
      bus <= 1'h1;
      settle;
      chk("bus without option", 32'h0, {31'h0, reg_en});
      ign <= 1'h0;
      bus <= 1'h0;
      settle;
      ign <= 1'h1;
      settle;
      chk("ignition wake", 32'h1, {31'h0, reg_en});
      chk("clamp off", 32'h0, {31'h0, clamp});
      ign <= 1'h0;
      settle;
      chk("pin fall keeps on", 32'h1, {31'h0, reg_en});
      wr(CTRL, 32'h0);
      bwopt <= 1'h1;
      settle;
      bus <= 1'h1;
      settle;
      chk("bus wake", 32'h1, {31'h0, reg_en});
      chk("clamp off by bus", 32'h0, {31'h0, clamp});
   endtask
   task automatic s_rst;
      wr(CTRL, 32'h41);
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      rdc(CTRL, 32'hFFFFFFFF, 32'h01, "ctrl after reset");
      chk("enable through reset", 32'h1, {31'h0, reg_en});
   endtask
   task automatic s_noopt;
      ign <= 1'h1;
      ropt <= 1'h0;
      settle;
      chk("enable without option", 32'h0, {31'h0, reg_en});
      rdc(CTRL, 32'hFFFFFFFF, 32'h01, "flag hidden");
      wr(CTRL, 32'h0);
      settle;
      chk("clamp without option", 32'h1, {31'h0, clamp});
      ropt <= 1'h1;
   endtask
   task automatic s_uv;
      ign <= 1'h0;
      settle;
      ign <= 1'h1;
      settle;
      vdd <= 1'h0;
      settle;
      chk("reset on supply loss", 32'h1, {31'h0, uvr});
      vdd <= 1'h1;
      repeat (PC) @(posedge clk);
      chk("reset held", 32'h1, {31'h0, uvr});
      repeat (30) @(posedge clk);
      chk("reset released", 32'h0, {31'h0, uvr});
      batt <= 1'h0;
      settle;
      rdc(ST, 32'h7, 32'h1, "mode off");
      chk("enable on battery loss", 32'h0, {31'h0, reg_en});
      batt <= 1'h1;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      por <= 1'h0;
      rst <= 1'h0;
      s_reset;
      s_wake;
      s_cmp;
      s_off;
      s_rst;
      s_noopt;
      s_uv;
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      end_sim;
   end
endmodule // rpmc_top_bench
